// ### rtl/spi_control_modes.sv
// serial peripheral port: control modes, master sequencer, slave shifter, registers
// assumes all pins are asynchronous to clock; pad wire levels resolved outside
`timescale 1ns/1ps

module spi_control_modes #(
   parameter int DIV_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire logic [spi_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic [spi_ctrl_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [spi_ctrl_pkg::DATA_W-1:0] rdata,
   // interrupt
   output logic irq,
   // serial clock
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   // slave select, active low
   input wire logic ss_n_i,
   output logic ss_n_o,
   output logic ss_n_oe,
   // master out, slave in
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   // master in, slave out
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe
);
   import spi_ctrl_pkg::*;

   if (DIV_W < 1 || DIV_W > 16) begin : div_w_check
      $error("DIV_W must lie between 1 and 16");
   end

   typedef struct packed {
      logic [15:0] ctrl;
      logic [DIV_W-1:0] div;
      logic [DIV_W-1:0] tick_cnt;
      logic [7:0] tx_hold;
      logic tx_valid;
      logic [7:0] last_tx;
      logic [7:0] rx_data;
      logic rx_full;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic [DATA_W-1:0] rdata;
      mstate_t state;
      logic [3:0] half;
      logic [7:0] shift;
      logic [7:0] rx_shift;
      logic start_req;
      logic [2:0] s_bits;
      logic s_loaded;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic ss_s1;
      logic ss_s2;
      logic mosi_s1;
      logic mosi_s2;
      logic miso_s1;
      logic miso_s2;
   } state_t;

   state_t s_reg;
   state_t s_next;

   function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
      return lsb ? sh[0] : sh[7];
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb);
      return lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
      return lsb ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction

   logic en;
   logic m_en;
   logic s_en;
   logic lsb;
   logic cpol;
   logic cpha;
   logic trig;
   logic cont;
   logic have_data;
   logic [7:0] load_byte;
   logic cur_bit;
   logic ser_in;
   logic tick;
   logic load;
   logic sample;
   logic byte_done;
   logic [7:0] rx_byte;
   logic lead;
   logic trail;
   logic open_drain_m;
   logic open_drain_s;
   logic [IRQ_W-1:0] ev;

   always_comb begin
      s_next = s_reg;
      en = s_reg.ctrl[B_PORT_EN];
      m_en = en & s_reg.ctrl[B_MASTER];
      s_en = en & ~s_reg.ctrl[B_MASTER];
      lsb = s_reg.ctrl[B_LSB_FIRST];
      cpol = s_reg.ctrl[B_CPOL];
      cpha = s_reg.ctrl[B_CPHA];
      trig = s_reg.ctrl[B_TRIGGER];
      cont = s_reg.ctrl[B_CONTINUOUS];
      // flush hides held data so only fill bytes go out
      have_data = s_reg.tx_valid & ~s_reg.ctrl[B_TX_FLUSH];
      load_byte = have_data ? s_reg.tx_hold : (s_reg.ctrl[B_ZERO_FILL] ? 8'h00 : s_reg.last_tx);
      cur_bit = out_bit(s_reg.shift, lsb);
      ser_in = s_reg.ctrl[B_LOOPBACK] ? cur_bit : (m_en ? s_reg.miso_s2 : s_reg.mosi_s2);
      tick = (s_reg.tick_cnt == s_reg.div);
      load = 1'b0;
      sample = 1'b0;
      byte_done = 1'b0;
      rx_byte = s_reg.rx_shift;
      lead = (s_reg.sclk_s2 != cpol) && (s_reg.sclk_s3 == cpol);
      trail = (s_reg.sclk_s2 == cpol) && (s_reg.sclk_s3 != cpol);
      ev = '0;

      // input synchronisers
      s_next.sclk_s1 = sclk_i;
      s_next.sclk_s2 = s_reg.sclk_s1;
      s_next.sclk_s3 = s_reg.sclk_s2;
      s_next.ss_s1 = ss_n_i;
      s_next.ss_s2 = s_reg.ss_s1;
      s_next.mosi_s1 = mosi_i;
      s_next.mosi_s2 = s_reg.mosi_s1;
      s_next.miso_s1 = miso_i;
      s_next.miso_s2 = s_reg.miso_s1;

      // register writes and read side effects that precede the serial logic
      s_next.rdata = '0;
      if (wr) begin
         unique case (addr)
            OFF_CONTROL: s_next.ctrl = wdata[15:0];
            OFF_DIVIDER: s_next.div = wdata[DIV_W-1:0];
            OFF_IRQ_ENABLE: s_next.irq_en = wdata[IRQ_W-1:0];
            OFF_IRQ_CLEAR: s_next.irq_stat = s_reg.irq_stat & ~wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            OFF_CONTROL: s_next.rdata = {16'h0000, s_reg.ctrl};
            OFF_RX: begin
               s_next.rdata = {24'h000000, s_reg.rx_data};
               s_next.rx_full = 1'b0;
               if (m_en && !trig) begin
                  s_next.start_req = 1'b1;
               end
            end
            OFF_IRQ_STATUS: s_next.rdata = {{(DATA_W-IRQ_W){1'b0}}, s_reg.irq_stat};
            OFF_IRQ_ENABLE: s_next.rdata = {{(DATA_W-IRQ_W){1'b0}}, s_reg.irq_en};
            OFF_DIVIDER: s_next.rdata = {{(DATA_W-DIV_W){1'b0}}, s_reg.div};
            OFF_FLAGS: s_next.rdata = {29'h00000000, (s_reg.state != ST_IDLE) | s_reg.s_loaded,
               s_reg.rx_full, s_reg.tx_valid};
            default: s_next.rdata = '0;
         endcase
      end

      // master sequencer, one tick per half bit
      unique case (s_reg.state)
         ST_IDLE: begin
            s_next.tick_cnt = '0;
            s_next.half = '0;
            if (m_en && (trig ? have_data : s_reg.start_req)) begin
               load = 1'b1;
               s_next.state = ST_XFER;
            end
         end
         ST_XFER: begin
            s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1;
            if (tick) begin
               s_next.half = s_reg.half + 4'h1;
               // data moves at bit start, sampled mid-bit, whatever the phase
               if (!s_reg.half[0]) begin
                  sample = 1'b1;
               end else if (s_reg.half == LAST_HALF) begin
                  byte_done = 1'b1;
                  s_next.half = '0;
                  if (cont && have_data) begin
                     load = 1'b1;
                  end else if (cont) begin
                     s_next.state = ST_IDLE;
                  end else begin
                     s_next.state = ST_STALL;
                  end
               end else begin
                  s_next.shift = shift_out(s_reg.shift, lsb);
               end
            end
         end
         ST_STALL: begin
            s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1;
            if (tick) begin
               s_next.half = s_reg.half + 4'h1;
               if (s_reg.half == STALL_LAST_HALF) begin
                  s_next.half = '0;
                  s_next.state = ST_IDLE;
               end
            end
         end
      endcase

      // slave shifter on synchronised clock edges
      if (s_en && s_reg.ss_s2) begin
         s_next.s_bits = '0;
         s_next.s_loaded = 1'b0;
      end else if (s_en) begin
         if (!s_reg.s_loaded) begin
            load = 1'b1;
            s_next.s_loaded = 1'b1;
         end else begin
            if (cpha ? trail : lead) begin
               sample = 1'b1;
               s_next.s_bits = s_reg.s_bits + 3'h1;
               if (s_reg.s_bits == LAST_BIT) begin
                  byte_done = 1'b1;
                  rx_byte = shift_in(s_reg.rx_shift, ser_in, lsb);
                  s_next.s_loaded = 1'b0;
               end
            end
            if ((cpha ? lead : trail) && s_reg.s_bits != 3'h0) begin
               s_next.shift = shift_out(s_reg.shift, lsb);
            end
         end
      end

      if (sample) begin
         s_next.rx_shift = shift_in(s_reg.rx_shift, ser_in, lsb);
      end
      if (load) begin
         s_next.shift = load_byte;
         s_next.last_tx = load_byte;
         s_next.start_req = 1'b0;
         if (have_data) begin
            s_next.tx_valid = 1'b0;
            ev[IRQ_TX_EMPTY] = trig;
         end
      end
      // receive flush drops incoming bytes and their events
      if (byte_done && !s_reg.ctrl[B_RX_FLUSH]) begin
         if (!s_next.rx_full || s_reg.ctrl[B_RX_OVERWRITE]) begin
            s_next.rx_data = rx_byte;
         end
         ev[IRQ_OVERFLOW] = s_next.rx_full;
         s_next.rx_full = 1'b1;
         ev[IRQ_RX_FULL] = ~trig;
      end

      // disabled port forgets any transfer in flight
      if (!en) begin
         s_next.state = ST_IDLE;
         s_next.s_loaded = 1'b0;
         s_next.s_bits = '0;
         s_next.start_req = 1'b0;
      end
      // a write after the load keeps the newer byte valid
      if (wr && addr == OFF_TX && !s_reg.ctrl[B_TX_FLUSH]) begin
         s_next.tx_hold = wdata[7:0];
         s_next.tx_valid = 1'b1;
      end
      // events set after the clear so a coincident event is kept
      s_next.irq_stat = s_next.irq_stat | ev;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ctrl <= CONTROL_RESET;
         s_reg.div <= DIV_W'(DIVIDER_RESET);
         s_reg.irq_stat <= IRQ_RESET;
         s_reg.irq_en <= IRQ_RESET;
         s_reg.state <= ST_IDLE;
         s_reg.sclk_s1 <= 1'b0;
         s_reg.ss_s1 <= 1'b1;
         s_reg.ss_s2 <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // pin drivers
   always_comb begin
      open_drain_m = s_reg.ctrl[B_WIRED_OR];
      open_drain_s = s_reg.ctrl[B_WIRED_OR] | ~s_reg.ctrl[B_SLAVE_OUT_DRIVE];
      rdata = s_reg.rdata;
      irq = |(s_reg.irq_stat & s_reg.irq_en);
      sclk_oe = m_en;
      sclk_o = m_en & (cpol ^ ((s_reg.state == ST_XFER) & (s_reg.half[0] ^ cpha)));
      ss_n_oe = m_en;
      ss_n_o = ~(m_en & (s_reg.state == ST_XFER));
      mosi_o = open_drain_m ? 1'b0 : cur_bit;
      mosi_oe = m_en & (open_drain_m ? ~cur_bit : 1'b1);
      miso_o = open_drain_s ? 1'b0 : cur_bit;
      miso_oe = s_en & ~s_reg.ss_s2 & s_reg.s_loaded & (open_drain_s ? ~cur_bit : 1'b1);
   end

   property p_disabled;
      @(posedge clock) disable iff (rst)
      !s_reg.ctrl[B_PORT_EN] |-> ss_n_o && !sclk_oe && !mosi_oe && !miso_oe;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled port drives a pin");

   property p_idle_polarity;
      @(posedge clock) disable iff (rst)
      (m_en && s_reg.state != ST_XFER) |-> (sclk_o == s_reg.ctrl[B_CPOL]);
   endproperty
   a_idle_polarity: assert property (p_idle_polarity) else $error("idle clock level wrong");

   property p_slave_od;
      @(posedge clock) disable iff (rst)
      (s_en && !s_reg.ctrl[B_SLAVE_OUT_DRIVE]) |-> !(miso_oe && miso_o);
   endproperty
   a_slave_od: assert property (p_slave_od) else $error("slave out driven high");

   property p_wired_or;
      @(posedge clock) disable iff (rst)
      s_reg.ctrl[B_WIRED_OR] |-> !(mosi_oe && mosi_o) && !(miso_oe && miso_o);
   endproperty
   a_wired_or: assert property (p_wired_or) else $error("wired-or output driven high");

   property p_cont_hold;
      @(posedge clock) disable iff (rst)
      (m_en && s_reg.state == ST_XFER && tick && s_reg.half == LAST_HALF && cont && have_data)
         |=> (s_reg.state == ST_XFER && !ss_n_o && s_reg.half == 4'h0);
   endproperty
   a_cont_hold: assert property (p_cont_hold) else $error("select dropped between bytes");

   property p_cont_end;
      @(posedge clock) disable iff (rst)
      (m_en && s_reg.state == ST_XFER && tick && s_reg.half == LAST_HALF && cont && !have_data)
         |=> (s_reg.state == ST_IDLE && ss_n_o);
   endproperty
   a_cont_end: assert property (p_cont_end) else $error("continuous run did not stop");

   property p_stall;
      @(posedge clock) disable iff (rst)
      (m_en && s_reg.state == ST_XFER && tick && s_reg.half == LAST_HALF && !cont && s_reg.ctrl[B_PORT_EN])
         |=> (s_reg.state == ST_STALL && ss_n_o) [*2];
   endproperty
   a_stall: assert property (p_stall) else $error("no stall after single byte");

   property p_tx_start;
      @(posedge clock) disable iff (rst)
      (m_en && trig && wr && addr == OFF_TX && !s_reg.ctrl[B_TX_FLUSH] && s_reg.state == ST_IDLE
         && !(wr && addr == OFF_CONTROL)) |-> ##[1:3] (s_reg.state == ST_XFER);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("transmit write did not start");

   property p_rx_irq_mode;
      @(posedge clock) disable iff (rst)
      $rose(s_reg.irq_stat[IRQ_RX_FULL]) |-> !$past(s_reg.ctrl[B_TRIGGER]);
   endproperty
   a_rx_irq_mode: assert property (p_rx_irq_mode) else $error("receive event in transmit mode");

   property p_discard;
      @(posedge clock) disable iff (rst)
      (byte_done && !s_reg.ctrl[B_RX_FLUSH] && s_reg.rx_full && !s_reg.ctrl[B_RX_OVERWRITE]
         && !(rd && addr == OFF_RX) && !(wr && addr == OFF_CONTROL)) |=> (s_reg.rx_data == $past(s_reg.rx_data));
   endproperty
   a_discard: assert property (p_discard) else $error("overflow byte not discarded");

   property p_zero_fill;
      @(posedge clock) disable iff (rst)
      (load && !have_data && s_reg.ctrl[B_ZERO_FILL]) |=> (s_reg.shift == 8'h00);
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("fill byte not zero");

endmodule

// ### rtl/spi_ctrl_pkg.sv
// constants, register map and state encoding of the serial port control block
// assumes a single 50 MHz system clock and a plain register port
package spi_ctrl_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CLOCK_MHZ = 50;

   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_TX = 8'h04;
   localparam logic [7:0] OFF_RX = 8'h08;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] OFF_DIVIDER = 8'h18;
   localparam logic [7:0] OFF_FLAGS = 8'h1c;

   // control register fields
   localparam int B_PORT_EN = 0;
   localparam int B_MASTER = 1;
   localparam int B_CPHA = 2;
   localparam int B_CPOL = 3;
   localparam int B_WIRED_OR = 4;
   localparam int B_LSB_FIRST = 5;
   localparam int B_TRIGGER = 6;
   localparam int B_ZERO_FILL = 7;
   localparam int B_RX_OVERWRITE = 8;
   localparam int B_SLAVE_OUT_DRIVE = 9;
   localparam int B_LOOPBACK = 10;
   localparam int B_CONTINUOUS = 11;
   localparam int B_RX_FLUSH = 12;
   localparam int B_TX_FLUSH = 13;

   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_TX_EMPTY = 0;
   localparam int IRQ_RX_FULL = 1;
   localparam int IRQ_OVERFLOW = 2;

   // flags register bits
   localparam int F_TX_VALID = 0;
   localparam int F_RX_FULL = 1;
   localparam int F_BUSY = 2;

   // reset values
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [7:0] DIVIDER_RESET = 8'h03;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // timing: half bit periods per byte and per stall
   localparam logic [3:0] LAST_HALF = 4'hf;
   localparam logic [3:0] STALL_LAST_HALF = 4'h1;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_STALL = 3'b100
   } mstate_t;

endpackage

// ### test/spi_peer_model.sv
// peer serial device that answers the port while the port is master
// assumes its clock mode inputs mirror the port's polarity and phase bits
`timescale 1ns/1ps
module spi_peer_model (
   // link
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   // setup and results
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] base,
   output logic [7:0] rx_byte,
   output int n_bytes
);
   logic [7:0] sh = 8'h00;
   logic [2:0] n = 3'h0;
   logic out = 1'b0;
   logic [7:0] tx;
   // each byte differs, so a dropped or repeated byte shows
   assign tx = base + 8'(n_bytes);
   // released line shows the inverse, not a stale bit
   assign miso = ss_n ? ~out : out;
   initial begin
      n_bytes = 0;
      rx_byte = 8'h00;
   end
   always @(negedge ss_n) begin
      n = 3'h0;
      out = tx[7];
   end
   always @(sclk) begin
      if (!ss_n) begin
         if (sclk == (cpol ^ ~cpha)) begin
            sh = {sh[6:0], mosi};
            n = n + 3'h1;
            if (n == 3'h0) begin
               rx_byte = sh;
               n_bytes++;
            end
         end else begin
            out = tx[3'h7 - n];
         end
      end
   end
endmodule

// ### test/testbench.sv
// self-checking bench for the serial port control block
// assumes the peer model is compiled first; bench plays master when the port is slave
`timescale 1ns/1ps
module testbench;
   import spi_ctrl_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, v;
   logic irq, sclk_o, sclk_oe, ss_n_o, ss_n_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso;
   logic m_sclk = 1'b0;
   logic m_ss_n = 1'b1;
   logic m_mosi = 1'b1;
   logic cpol = 1'b0;
   logic cpha = 1'b0;
   logic is_master = 1'b0;
   logic od_chk = 1'b0;
   logic [7:0] base = 8'h00;
   logic [7:0] p_rx, sl_got;
   int p_bytes;
   int n_errors = 0;
   int n_checks = 0;
   int n_rise = 0;
   int n_bad = 0;
   realtime t_rise = 0;
   realtime gap = 0;
   // board pull-ups on data lines when nobody drives
   wire sclk_w = sclk_oe ? sclk_o : m_sclk;
   wire ss_w = ss_n_oe ? ss_n_o : m_ss_n;
   wire mosi_w = mosi_oe ? mosi_o : m_mosi;
   wire miso_w = miso_oe ? miso_o : (is_master ? p_miso : 1'b1);

   spi_control_modes dut_u (
      .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe)
   );
   spi_peer_model peer_u (
      .sclk(sclk_w), .ss_n(ss_w | ~is_master), .mosi(mosi_w), .miso(p_miso),
      .cpol(cpol), .cpha(cpha), .base(base), .rx_byte(p_rx), .n_bytes(p_bytes)
   );

   initial begin
      forever #10 clock = ~clock;
   end
   always @(posedge ss_w) begin
      n_rise++;
      t_rise = $realtime;
   end
   always @(negedge ss_w) gap = $realtime - t_rise;
   // open-drain outputs may only ever pull low
   always @(posedge clock) if (od_chk && ((mosi_oe && mosi_o !== 1'b0) || (miso_oe && miso_o !== 1'b0))) n_bad++;

   function automatic logic [15:0] fb(input int b);
      return 16'h1 << b;
   endfunction
   function automatic logic [7:0] rev(input logic [7:0] x);
      logic [7:0] y;
      for (int i = 0; i < 8; i++) y[i] = x[7 - i];
      return y;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic idle();
      int k;
      k = 0;
      repeat (3) @(posedge clock);
      do begin
         rreg(OFF_FLAGS, v);
         k++;
      end while ((v[F_BUSY] | v[F_TX_VALID]) !== 1'b0 && k < 400);
      if (k >= 400) chk("busy", 32'h0, v);
   endtask
   // master run: set mode, drop held rx byte, send n bytes
   task automatic mxfer(input logic [15:0] c, input logic [7:0] d, input logic [7:0] pb, input int n);
      cpol = c[B_CPOL];
      cpha = c[B_CPHA];
      base = pb;
      is_master = 1'b1;
      wreg(OFF_CONTROL, c);
      rreg(OFF_RX, v);
      for (int i = 0; i < n; i++) begin
         if (i > 0) repeat (4) @(posedge clock);
         wreg(OFF_TX, d);
      end
      idle();
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      test_done();
   end

   initial begin
      logic [15:0] c;
      logic [7:0] d, e;
      int b;
      void'($urandom(73));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rreg(OFF_CONTROL, v);
      chk("control reset", CONTROL_RESET, v);
      rreg(OFF_DIVIDER, v);
      chk("divider reset", DIVIDER_RESET, v);
      rreg(8'hfc, v);
      chk("unmapped", 32'h0, v);
      chk("drivers off", 4'h0, {sclk_oe, ss_n_oe, mosi_oe, miso_oe});
      // every clock mode and bit order, irq masked on the first pass
      for (int m = 0; m < 8; m++) begin
         c = fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | (m[0] ? fb(B_CPHA) : 16'h0);
         c = c | (m[1] ? fb(B_CPOL) : 16'h0) | (m[2] ? fb(B_LSB_FIRST) : 16'h0);
         wreg(OFF_IRQ_ENABLE, m == 0 ? 32'h0 : 32'h7);
         d = 8'($urandom);
         e = 8'($urandom);
         b = p_bytes;
         mxfer(c, d, e, 1);
         chk("peer count", b + 1, p_bytes);
         chk("peer rx", m[2] ? rev(d) : d, p_rx);
         rreg(OFF_RX, v);
         chk("port rx", m[2] ? rev(8'(e + 8'(b))) : 8'(e + 8'(b)), v);
         chk("sclk idle", m[1], sclk_o);
         rreg(OFF_IRQ_STATUS, v);
         chk("irq status", 32'h1 << IRQ_TX_EMPTY, v);
         chk("irq line", m != 0, irq);
         wreg(OFF_IRQ_CLEAR, 32'h7);
         rreg(OFF_IRQ_STATUS, v);
         chk("irq cleared", 32'h0, {v[31:1], irq});
      end
      // single bytes with stall, then continuous
      for (int k = 0; k < 2; k++) begin
         b = p_bytes;
         n_rise = 0;
         mxfer(fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | (k ? fb(B_CONTINUOUS) : 16'h0), 8'h3c, 8'h00, 2);
         chk("two bytes", b + 2, p_bytes);
         chk("select rises", k ? 1 : 2, n_rise);
         if (k == 0) chk("stall", 1, gap >= 160.0);
         chk("select idle", 1, ss_w);
      end
      // read-triggered: flushing ignores tx writes and sends zeros
      c = fb(B_PORT_EN) | fb(B_MASTER) | fb(B_ZERO_FILL) | fb(B_TX_FLUSH);
      wreg(OFF_CONTROL, c);
      wreg(OFF_IRQ_CLEAR, 32'h7);
      wreg(OFF_TX, 32'h5a);
      b = p_bytes;
      rreg(OFF_RX, v);
      idle();
      chk("rx read starts", b + 1, p_bytes);
      chk("flush zeros", 8'h00, p_rx);
      rreg(OFF_IRQ_STATUS, v);
      chk("rx irq only", 32'h1 << IRQ_RX_FULL, v);
      c = fb(B_PORT_EN) | fb(B_MASTER);
      wreg(OFF_CONTROL, c);
      d = 8'($urandom);
      wreg(OFF_TX, d);
      repeat (20) @(posedge clock);
      chk("tx write idle", b + 1, p_bytes);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) wreg(OFF_CONTROL, c | fb(B_ZERO_FILL));
         rreg(OFF_RX, v);
         idle();
         chk("empty tx fill", i < 2 ? d : 8'h00, p_rx);
      end
      // overflow: discard then overwrite; stale flag cleared so each pass must set it
      for (int k = 0; k < 2; k++) begin
         e = 8'($urandom);
         b = p_bytes;
         wreg(OFF_IRQ_CLEAR, 32'h7);
         mxfer(fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | (k ? fb(B_RX_OVERWRITE) : 16'h0), 8'h11, e, 2);
         rreg(OFF_RX, v);
         chk("overflow rx", 8'(e + 8'(b + k)), v);
         rreg(OFF_IRQ_STATUS, v);
         chk("overflow flag", 1, v[IRQ_OVERFLOW]);
      end
      // receive flush drops the byte and its receive events
      wreg(OFF_IRQ_CLEAR, 32'h7);
      mxfer(fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | fb(B_RX_FLUSH), 8'h22, 8'h00, 1);
      rreg(OFF_IRQ_STATUS, v);
      chk("rx flush events", 32'h1 << IRQ_TX_EMPTY, v);
      rreg(OFF_FLAGS, v);
      chk("rx flush full", 0, v[F_RX_FULL]);
      // loopback ignores the peer's reply
      d = 8'($urandom);
      mxfer(fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | fb(B_LOOPBACK), d, 8'(~d - 8'(p_bytes)), 1);
      rreg(OFF_RX, v);
      chk("loopback", d, v);
      // watch armed only once wired-or is in force, else the old push-pull bit counts
      c = fb(B_PORT_EN) | fb(B_MASTER) | fb(B_TRIGGER) | fb(B_WIRED_OR);
      wreg(OFF_CONTROL, c);
      @(posedge clock);
      od_chk = 1'b1;
      d = 8'($urandom);
      mxfer(c, d, 8'h00, 1);
      chk("wired-or data", d, p_rx);
      // slave, open-drain data out; bench is the far master in mode zero
      is_master = 1'b0;
      wreg(OFF_CONTROL, fb(B_PORT_EN) | fb(B_TRIGGER));
      rreg(OFF_RX, v);
      d = 8'($urandom);
      e = 8'($urandom);
      wreg(OFF_TX, d);
      m_ss_n <= 1'b0;
      // select passes the synchroniser and loads the byte before the first edge
      repeat (4) @(posedge clock);
      for (int i = 7; i >= 0; i--) begin
         m_mosi <= e[i];
         repeat (4) @(posedge clock);
         m_sclk <= 1'b1;
         sl_got[i] = miso_w;
         repeat (4) @(posedge clock);
         m_sclk <= 1'b0;
      end
      repeat (4) @(posedge clock);
      m_ss_n <= 1'b1;
      m_mosi <= 1'b1;
      chk("slave drives no clock", 2'h0, {sclk_oe, ss_n_oe});
      repeat (10) @(posedge clock);
      rreg(OFF_RX, v);
      chk("slave rx", e, v);
      chk("slave tx", d, sl_got);
      chk("open-drain", 0, n_bad);
      wreg(OFF_CONTROL, fb(B_MASTER));
      rreg(OFF_FLAGS, v);
      chk("disabled", 4'h0, {sclk_oe, ss_n_oe, mosi_oe, miso_oe});
      test_done();
   end
endmodule
